// [hdl/rfr_regs.v]
// Purpose: Configuration register bank of the radio: amplifier control,
//          packet buffer pointers, interrupt mask and flags.
// Assumes: Register port and modem events are on mclk; single-cycle strobes.
// Notes:   Read data appear in the cycle after the read strobe only.
//          Flags clear by a write of one or by a read that returns them;
//          an event in the clearing cycle survives.
//          Writes to read-only or unmapped offsets are dropped.
//          Outputs all come from flip-flops; amplifier controls lag a cycle.
//
// The plain strobed port was chosen for this implementation.
`include "rfr_consts.vh"

module rfr_regs (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Modem events, one-cycle pulses, bit order as the flag register
  input wire [7:0] modem_event,
  // Receive packet start from the demodulator
  input wire rx_start_load,
  input wire [7:0] rx_start_addr,
  // Host access to the packet buffer advances the pointer
  input wire host_buf_access,
  // Amplifier controls
  output wire [2:0] rx_amp_gain_step,
  output wire gain_code_unused,
  output wire [1:0] low_band_amp_current,
  output wire [1:0] high_band_amp_current,
  output wire high_band_boost,
  // Buffer pointers
  output reg [7:0] host_buffer_pointer,
  output reg [7:0] tx_buffer_base,
  output reg [7:0] rx_buffer_base,
  // Interrupt
  output wire irq_out
);

  // ----------------------------------------------------------------------
  // Stored registers
  // ----------------------------------------------------------------------
  reg [2:0] gain_code_r;
  reg [1:0] low_cur_r;
  reg [1:0] high_cur_r;
  reg [7:0] last_rx_packet_start_r;
  reg [7:0] irq_source_mask_r;
  reg low_rsvd_seen_r;
  reg amp_rsvd_seen_r;
  reg [7:0] rdata_nxt;
  reg [2:0] gain_code_nxt;
  reg [1:0] low_cur_nxt;
  reg [1:0] high_cur_nxt;
  reg low_rsvd_seen_nxt;
  reg amp_rsvd_seen_nxt;
  reg [7:0] host_buffer_pointer_nxt;
  reg [7:0] tx_buffer_base_nxt;
  reg [7:0] rx_buffer_base_nxt;
  reg [7:0] last_rx_packet_start_nxt;
  reg [7:0] irq_source_mask_nxt;
  reg [7:0] flag_clear;
  wire [7:0] irq_flags;
  wire low_band_reserved;
  wire [8:0] ptr_inc;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Exact compare on all address bits, so aliases never reach a register
  function is_addr;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  // Bit 2 reads zero as it is never stored
  function [7:0] amp_word;
    input [2:0] gain;
    input [1:0] low_cur;
    input [1:0] high_cur;
    begin
      amp_word = {gain, low_cur, 1'b0, high_cur};
    end
  endfunction

  // Status bits from the bottom: boost, unused gain code,
  // reserved low-band code seen, reserved bit written as one
  function [7:0] status_word;
    input amp_rsvd;
    input low_rsvd;
    input unused_gain;
    input boost;
    begin
      status_word = {4'h0, amp_rsvd, low_rsvd, unused_gain, boost};
    end
  endfunction

  wire wr_amp = reg_wr && is_addr(reg_addr, `RFR_OFS_RX_AMP_CONTROL);
  wire wr_ptr = reg_wr && is_addr(reg_addr, `RFR_OFS_HOST_BUFFER_POINTER);
  wire wr_txb = reg_wr && is_addr(reg_addr, `RFR_OFS_TX_BUFFER_BASE);
  wire wr_rxb = reg_wr && is_addr(reg_addr, `RFR_OFS_RX_BUFFER_BASE);
  wire wr_msk = reg_wr && is_addr(reg_addr, `RFR_OFS_IRQ_SOURCE_MASK);
  wire wr_flg = reg_wr && is_addr(reg_addr, `RFR_OFS_IRQ_FLAG_REGISTER);
  wire rd_flg = reg_rd && is_addr(reg_addr, `RFR_OFS_IRQ_FLAG_REGISTER);
  wire rd_sts = reg_rd && is_addr(reg_addr, `RFR_OFS_AMP_STATUS);

  // ----------------------------------------------------------------------
  // Amplifier control register
  // ----------------------------------------------------------------------
  // Reserved bit 2 is not stored, so a stray write cannot steer anything
  always @*
  begin
    gain_code_nxt = gain_code_r;
    low_cur_nxt = low_cur_r;
    high_cur_nxt = high_cur_r;
    if (wr_amp)
    begin
      gain_code_nxt = reg_wdata[`RFR_GAIN_MSB:`RFR_GAIN_LSB];
      low_cur_nxt = reg_wdata[`RFR_LOW_CUR_MSB:`RFR_LOW_CUR_LSB];
      high_cur_nxt = reg_wdata[`RFR_HIGH_CUR_MSB:`RFR_HIGH_CUR_LSB];
    end
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      gain_code_r <= `RFR_RST_GAIN;
      low_cur_r <= `RFR_CUR_DEFAULT;
      high_cur_r <= `RFR_CUR_DEFAULT;
    end
    else
    begin
      gain_code_r <= gain_code_nxt;
      low_cur_r <= low_cur_nxt;
      high_cur_r <= high_cur_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Misuse status
  // ----------------------------------------------------------------------
  // Sticky notes of misuse: reserved low-band code or reserved bit written.
  // A status read clears them, but a misuse in that same cycle is kept,
  // so nothing is lost between two reads.
  always @*
  begin
    low_rsvd_seen_nxt = low_rsvd_seen_r;
    amp_rsvd_seen_nxt = amp_rsvd_seen_r;
    if (rd_sts)
    begin
      low_rsvd_seen_nxt = 1'b0;
      amp_rsvd_seen_nxt = 1'b0;
    end
    if (low_band_reserved)
      low_rsvd_seen_nxt = 1'b1;
    if (wr_amp && reg_wdata[`RFR_RSVD_BIT])
      amp_rsvd_seen_nxt = 1'b1;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      low_rsvd_seen_r <= 1'b0;
      amp_rsvd_seen_r <= 1'b0;
    end
    else
    begin
      low_rsvd_seen_r <= low_rsvd_seen_nxt;
      amp_rsvd_seen_r <= amp_rsvd_seen_nxt;
    end
  end

  // Decoded amplifier controls lag the stored fields by one cycle
  rfr_amp_decode u_amp (
    .mclk(mclk),
    .rstn(rstn),
    .gain_code(gain_code_r),
    .low_cur_code(low_cur_r),
    .high_cur_code(high_cur_r),
    .rx_amp_gain_step(rx_amp_gain_step),
    .gain_code_unused(gain_code_unused),
    .low_band_amp_current(low_band_amp_current),
    .low_band_reserved(low_band_reserved),
    .high_band_amp_current(high_band_amp_current),
    .high_band_boost(high_band_boost)
  );

  // ----------------------------------------------------------------------
  // Packet buffer pointers
  // ----------------------------------------------------------------------
  // A host write of the pointer takes priority over a buffer access advance;
  // the advance wraps from the top of the buffer back to zero
  assign ptr_inc = {1'b0, host_buffer_pointer} + 9'h001;

  always @*
  begin
    host_buffer_pointer_nxt = host_buffer_pointer;
    tx_buffer_base_nxt = tx_buffer_base;
    rx_buffer_base_nxt = rx_buffer_base;
    if (wr_ptr)
      host_buffer_pointer_nxt = reg_wdata;
    else if (host_buf_access)
      host_buffer_pointer_nxt = ptr_inc[7:0];
    if (wr_txb)
      tx_buffer_base_nxt = reg_wdata;
    if (wr_rxb)
      rx_buffer_base_nxt = reg_wdata;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      host_buffer_pointer <= `RFR_RST_HOST_BUFFER_POINTER;
      tx_buffer_base <= `RFR_RST_TX_BUFFER_BASE;
      rx_buffer_base <= `RFR_RST_RX_BUFFER_BASE;
    end
    else
    begin
      host_buffer_pointer <= host_buffer_pointer_nxt;
      tx_buffer_base <= tx_buffer_base_nxt;
      rx_buffer_base <= rx_buffer_base_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Last received packet start
  // ----------------------------------------------------------------------
  // Reset value is left undefined for software; zero is used here
  always @*
  begin
    last_rx_packet_start_nxt = last_rx_packet_start_r;
    if (rx_start_load)
      last_rx_packet_start_nxt = rx_start_addr;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      last_rx_packet_start_r <= `RFR_RST_LAST_RX_PACKET_START;
    else
      last_rx_packet_start_r <= last_rx_packet_start_nxt;
  end

  // ----------------------------------------------------------------------
  // Interrupt mask and flags
  // ----------------------------------------------------------------------
  // A set mask bit drops its event and gates its flag out of the level
  always @*
  begin
    irq_source_mask_nxt = irq_source_mask_r;
    if (wr_msk)
      irq_source_mask_nxt = reg_wdata;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      irq_source_mask_r <= `RFR_RST_IRQ_SOURCE_MASK;
    else
      irq_source_mask_r <= irq_source_mask_nxt;
  end

  // Write one clears; a read of the flag register also clears what it saw.
  // Only the bits returned are cleared, so an event landing in the read
  // cycle stays pending for the next read.
  always @*
  begin
    flag_clear = 8'h00;
    if (wr_flg)
      flag_clear = reg_wdata;
    if (rd_flg)
      flag_clear = flag_clear | irq_flags;
  end

  rfr_irq_bank #(
    .N(8)
  ) u_irq (
    .mclk(mclk),
    .rstn(rstn),
    .event_pulse(modem_event),
    .suppress(irq_source_mask_r),
    .clear_bits(flag_clear),
    .flags(irq_flags),
    .irq(irq_out)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `RFR_OFS_RX_AMP_CONTROL:
        rdata_nxt = amp_word(gain_code_r, low_cur_r, high_cur_r);
      `RFR_OFS_HOST_BUFFER_POINTER:
        rdata_nxt = host_buffer_pointer;
      `RFR_OFS_TX_BUFFER_BASE:
        rdata_nxt = tx_buffer_base;
      `RFR_OFS_RX_BUFFER_BASE:
        rdata_nxt = rx_buffer_base;
      `RFR_OFS_LAST_RX_PACKET_START:
        rdata_nxt = last_rx_packet_start_r;
      `RFR_OFS_IRQ_SOURCE_MASK:
        rdata_nxt = irq_source_mask_r;
      `RFR_OFS_IRQ_FLAG_REGISTER:
        rdata_nxt = irq_flags;
      `RFR_OFS_AMP_STATUS:
        rdata_nxt = status_word(amp_rsvd_seen_r, low_rsvd_seen_r, gain_code_unused,
                                high_band_boost);
      default:
        rdata_nxt = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe; zero otherwise
  always @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end

endmodule

// [hdl/rfr_consts.vh]
// Purpose: Register offsets, field positions and reset values of the radio
//          configuration register bank.
// Assumes: 8-bit register address and 8-bit data.
// Notes:   Definitions only.
`ifndef RFR_CONSTS_VH
`define RFR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RFR_ADDR_W 8
`define RFR_DATA_W 8
`define RFR_OFS_RX_AMP_CONTROL 8'h0C
`define RFR_OFS_HOST_BUFFER_POINTER 8'h0D
`define RFR_OFS_TX_BUFFER_BASE 8'h0E
`define RFR_OFS_RX_BUFFER_BASE 8'h0F
`define RFR_OFS_LAST_RX_PACKET_START 8'h10
`define RFR_OFS_IRQ_SOURCE_MASK 8'h11
`define RFR_OFS_IRQ_FLAG_REGISTER 8'h12
`define RFR_OFS_AMP_STATUS 8'h1F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RFR_GAIN_MSB 7
`define RFR_GAIN_LSB 5
`define RFR_LOW_CUR_MSB 4
`define RFR_LOW_CUR_LSB 3
`define RFR_RSVD_BIT 2
`define RFR_HIGH_CUR_MSB 1
`define RFR_HIGH_CUR_LSB 0
`define RFR_IRQ_RX_TIMEOUT 7
`define RFR_IRQ_RX_COMPLETE 6
`define RFR_IRQ_CHECKSUM_ERR 5
`define RFR_IRQ_HEADER_OK 4
`define RFR_IRQ_TX_COMPLETE 3
`define RFR_IRQ_SCAN_COMPLETE 2
`define RFR_IRQ_HOP_CHANGE 1
`define RFR_IRQ_ACTIVITY_FOUND 0

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define RFR_GAIN_STEP_MAX 3'h1
`define RFR_GAIN_STEP_MIN 3'h6
`define RFR_CUR_DEFAULT 2'h0
`define RFR_CUR_BOOST 2'h3
`define RFR_RST_GAIN 3'h1
`define RFR_RST_HOST_BUFFER_POINTER 8'h00
`define RFR_RST_TX_BUFFER_BASE 8'h80
`define RFR_RST_RX_BUFFER_BASE 8'h00
`define RFR_RST_LAST_RX_PACKET_START 8'h00
`define RFR_RST_IRQ_SOURCE_MASK 8'h00
`define RFR_RST_IRQ_FLAGS 8'h00

`endif

// [hdl/rfr_amp_decode.v]
// Purpose: Registered decode of the receive amplifier control fields.
// Assumes: Fields come from registers on the same clock.
// Notes:   Unused gain codes keep the last valid step applied.
`include "rfr_consts.vh"

module rfr_amp_decode (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Stored fields
  input wire [2:0] gain_code,
  input wire [1:0] low_cur_code,
  input wire [1:0] high_cur_code,
  // Decoded controls
  output reg [2:0] rx_amp_gain_step,
  output reg gain_code_unused,
  output reg [1:0] low_band_amp_current,
  output reg low_band_reserved,
  output reg [1:0] high_band_amp_current,
  output reg high_band_boost
);

  function gain_ok;
    input [2:0] code;
    begin
      gain_ok = (code >= `RFR_GAIN_STEP_MAX) && (code <= `RFR_GAIN_STEP_MIN);
    end
  endfunction

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      rx_amp_gain_step <= `RFR_RST_GAIN;
      gain_code_unused <= 1'b0;
      low_band_amp_current <= `RFR_CUR_DEFAULT;
      low_band_reserved <= 1'b0;
      high_band_amp_current <= `RFR_CUR_DEFAULT;
      high_band_boost <= 1'b0;
    end
    else
    begin
      // Step 1 is maximum gain, step 6 minimum
      if (gain_ok(gain_code))
        rx_amp_gain_step <= gain_code;
      gain_code_unused <= !gain_ok(gain_code);
      // Only the default current is defined for the low band
      low_band_amp_current <= `RFR_CUR_DEFAULT;
      low_band_reserved <= (low_cur_code != `RFR_CUR_DEFAULT);
      high_band_amp_current <= high_cur_code;
      high_band_boost <= (high_cur_code == `RFR_CUR_BOOST);
    end
  end

endmodule

// [hdl/rfr_irq_bank.v]
// Purpose: Sticky interrupt flags with per-source suppress mask.
// Assumes: Events are one-cycle pulses on the register clock.
// Notes:   A set in the same cycle as a clear wins.
`include "rfr_consts.vh"

module rfr_irq_bank #(
  parameter N = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Sources and control
  input wire [N-1:0] event_pulse,
  input wire [N-1:0] suppress,
  input wire [N-1:0] clear_bits,
  // State
  output reg [N-1:0] flags,
  output reg irq
);

  wire [N-1:0] flags_nxt;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_flag
      // Suppressed sources never raise their flag
      assign flags_nxt[i] = (event_pulse[i] & ~suppress[i]) |
                            (flags[i] & ~clear_bits[i]);
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      flags <= `RFR_RST_IRQ_FLAGS;
      irq <= 1'b0;
    end
    else
    begin
      flags <= flags_nxt;
      // Mask also gates flags raised before the mask was set
      irq <= |(flags_nxt & ~suppress);
    end
  end

endmodule

// [sim/rfr_regs_checker.sv]
// Purpose: Port checks on the radio register bank.
// Assumes: One clock mclk, synchronous active-low rstn.
// Notes:   Bound to rfr_regs below.
module rfr_regs_checker (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Events and outputs
  input wire [7:0] modem_event,
  input wire host_buf_access,
  input wire [2:0] rx_amp_gain_step,
  input wire [1:0] low_band_amp_current,
  input wire high_band_boost,
  input wire [7:0] host_buffer_pointer,
  input wire [7:0] tx_buffer_base,
  input wire [7:0] rx_buffer_base,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_tx_base_wr: assert property (reg_wr && reg_addr == 8'h0E |=>
    tx_buffer_base == $past(reg_wdata)) else $error("tx base not written");
  chk_rx_base_wr: assert property (reg_wr && reg_addr == 8'h0F |=>
    rx_buffer_base == $past(reg_wdata)) else $error("rx base not written");
  chk_ptr_step: assert property (host_buf_access && !reg_wr |=>
    host_buffer_pointer == $past(host_buffer_pointer) + 8'h01) else $error("pointer step");
  chk_gain_apply: assert property (reg_wr && reg_addr == 8'h0C && reg_wdata[7:5] != 3'h0
    && reg_wdata[7:5] != 3'h7 |=> ##1 rx_amp_gain_step == $past(reg_wdata[7:5], 2))
    else $error("gain step not applied");
  chk_boost_map: assert property (reg_wr && reg_addr == 8'h0C |=> ##1
    high_band_boost == ($past(reg_wdata[1:0], 2) == 2'h3)) else $error("boost map");
  chk_low_cur: assert property (low_band_amp_current == 2'h0)
    else $error("low band current not default");
  chk_irq_cause: assert property ($rose(irq_out) |-> $past(modem_event) != 8'h00
    || $past(reg_wr && reg_addr == 8'h11, 2)) else $error("irq without cause");
endmodule

bind rfr_regs rfr_regs_checker chk_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .modem_event(modem_event), .host_buf_access(host_buf_access),
  .rx_amp_gain_step(rx_amp_gain_step), .low_band_amp_current(low_band_amp_current),
  .high_band_boost(high_band_boost), .host_buffer_pointer(host_buffer_pointer),
  .tx_buffer_base(tx_buffer_base), .rx_buffer_base(rx_buffer_base), .irq_out(irq_out));

// [sim/rfr_host_model.sv]
// Purpose: Host side of the register port.
// Assumes: One-cycle strobes, read data in the following cycle.
// Notes:   Released lines flip so a stale value never looks held.
module rfr_host_model (
  // Clock
  input wire mclk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= (a == 8'h0C) ? (d & 8'hFB) : d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~reg_wdata;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// [sim/testbench.sv]
// Purpose: Self-checking bench for the radio register bank.
// Assumes: Host model drives the register port.
// Notes:   Events and buffer pulses come from the bench.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] modem_event = 8'h00;
  logic [7:0] rx_start_addr = 8'h00;
  logic rx_start_load = 1'b0;
  logic host_buf_access = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, host_buffer_pointer, tx_buffer_base, rx_buffer_base;
  wire reg_wr, reg_rd, gain_code_unused, high_band_boost, irq_out;
  wire [2:0] rx_amp_gain_step;
  wire [1:0] low_band_amp_current, high_band_amp_current;
  logic [7:0] d;
  int num_errors = 0;
  int comparisons = 0;
  logic [7:0] rst_a [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h20};
  logic [7:0] rst_v [7] = '{8'h20, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

  rfr_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rfr_regs dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_event(modem_event),
    .rx_start_load(rx_start_load), .rx_start_addr(rx_start_addr),
    .host_buf_access(host_buf_access), .rx_amp_gain_step(rx_amp_gain_step),
    .gain_code_unused(gain_code_unused), .low_band_amp_current(low_band_amp_current),
    .high_band_amp_current(high_band_amp_current), .high_band_boost(high_band_boost),
    .host_buffer_pointer(host_buffer_pointer), .tx_buffer_base(tx_buffer_base),
    .rx_buffer_base(rx_buffer_base), .irq_out(irq_out));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic pulse(input logic [7:0] v);
    @(posedge mclk);
    modem_event <= v;
    @(posedge mclk);
    modem_event <= 8'h00;
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rst_a[i])
    begin
      host_u.rd(rst_a[i], d);
      `CHK(d, rst_v[i])
    end
    $display("reset values done");
    for (int i = 0; i < 5; i++)
    begin
      host_u.wr(8'h0D + i[7:0], 8'h3C + i[7:0]);
    end
    `CHK({host_buffer_pointer, tx_buffer_base, rx_buffer_base}, 24'h3C3D3E)
    host_u.rd(8'h11, d);
    `CHK(d, 8'h40)
    host_u.wr(8'h10, 8'hFF);
    host_u.rd(8'h10, d);
    `CHK(d, 8'h00)
    @(posedge mclk);
    rx_start_addr <= 8'h5A;
    rx_start_load <= 1'b1;
    @(posedge mclk);
    rx_start_load <= 1'b0;
    host_u.rd(8'h10, d);
    `CHK(d, 8'h5A)
    host_u.wr(8'h0D, 8'hFF);
    @(posedge mclk);
    host_buf_access <= 1'b1;
    @(posedge mclk);
    host_buf_access <= 1'b0;
    #1;
    `CHK(host_buffer_pointer, 8'h00)
    $display("pointers done");
    for (int g = 1; g < 8; g++)
    begin
      host_u.wr(8'h0C, {g[2:0], 5'h0F});
      @(posedge mclk);
      #1;
      `CHK({gain_code_unused, rx_amp_gain_step}, (g == 7) ? 4'hE : {1'b0, g[2:0]})
    end
    `CHK({high_band_boost, low_band_amp_current, high_band_amp_current}, 5'h13)
    host_u.rd(8'h0C, d);
    `CHK(d, 8'hEB)
    host_u.wr(8'h0C, 8'h20);
    @(posedge mclk);
    #1;
    `CHK({high_band_boost, high_band_amp_current}, 3'h0)
    host_u.rd(8'h1F, d);
    `CHK(d, 8'h04)
    host_u.rd(8'h1F, d);
    `CHK(d, 8'h00)
    $display("amplifier done");
    for (int i = 0; i < 8; i++)
    begin
      host_u.wr(8'h11, ~(8'h01 << i));
      pulse(8'hFF);
      `CHK(irq_out, 1'b1)
      host_u.rd(8'h12, d);
      `CHK({irq_out, d}, {1'b0, 8'h01 << i})
    end
    host_u.wr(8'h11, 8'h00);
    pulse(8'h04);
    host_u.wr(8'h12, 8'h04);
    `CHK(irq_out, 1'b0)
    pulse(8'h02);
    host_u.wr(8'h11, 8'h02);
    @(posedge mclk);
    #1;
    `CHK(irq_out, 1'b0)
    host_u.rd(8'h12, d);
    `CHK(d, 8'h02)
    $display("interrupts done");
    stop_test();
  end
endmodule
